// *** radio_strobe_pkg.sv ***
// Constants and types shared by the radio strobe sequencer.
// Assumes a single 200 MHz system clock and a CPU special-function bus.
`default_nettype none
package radio_strobe_pkg;
    // ********************************
    // Port addresses and register map
    // ********************************
    localparam logic [7:0] PORT_ADDR       = 8'he1;  // strobe_instruction_port
    localparam logic [7:0] PORT_RESET      = 8'hc0;
    localparam logic [2:0] RF_X_ADDR       = 3'h0;
    localparam logic [2:0] RF_Y_ADDR       = 3'h1;
    localparam logic [2:0] RF_Z_ADDR       = 3'h2;
    localparam logic [2:0] RF_T_ADDR       = 3'h3;
    localparam logic [2:0] RF_CTRL_ADDR    = 3'h4;
    localparam logic [7:0] T_HOLD_VALUE    = 8'hff;  // Countdown frozen at this value
    localparam int         CTRL_PAUSE_BIT  = 0;      // Writable: hold execution
    localparam int         CTRL_RUN_BIT    = 7;      // Read only: program running
    // ********************************
    // Instruction memory and opcodes
    // ********************************
    localparam int         MEM_DEPTH       = 24;
    localparam logic [4:0] MEM_LAST        = 5'd23;
    localparam logic [7:0] OP_NOP          = 8'hc0;  // no_op_strobe
    localparam logic [7:0] OP_WEVENT       = 8'hb8;
    localparam logic [7:0] OP_INT          = 8'hb9;
    localparam logic [7:0] OP_LABEL        = 8'hba;
    localparam logic [7:0] OP_WAITX        = 8'hbb;
    localparam logic [7:0] OP_INCY         = 8'hbd;
    localparam logic [7:0] OP_SSTOP        = 8'hdf;
    localparam logic [2:0] OP_WAIT_TOP     = 3'b100;
    localparam logic [3:0] OP_RPT_TOP      = 4'b1010;
    localparam logic [2:0] OP_STROBE_TOP   = 3'b110;
    localparam logic [2:0] OP_IMM_TOP      = 3'b111;
    localparam logic [7:0] OP_IMM_START    = 8'hfe;  // immediate_run_cmd
    localparam logic [7:0] OP_IMM_STOP     = 8'hff;
    localparam logic [5:0] WAIT_ZERO_COUNT = 6'd32;
    // ********************************
    // Timing
    // ********************************
    localparam int         SYS_CLOCK_HZ    = 200_000_000;
    localparam int         SEQ_CLOCK_HZ    = 8_000_000;
    localparam logic [4:0] TICK_LAST       = 5'(SYS_CLOCK_HZ / SEQ_CLOCK_HZ - 1);

    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_WAIT_OVF, ST_WAIT_EVT, ST_WAIT_X} seq_state_type;

    // CPU special-function access
    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       read;
        logic [7:0] wdata;
    } sfr_req_type;

    // CPU radio-register access
    typedef struct packed {
        logic [2:0] addr;
        logic       write;
        logic       read;
        logic [7:0] wdata;
    } rf_req_type;

    // Complete sequencer state
    typedef struct packed {
        seq_state_type              st;
        logic [MEM_DEPTH-1:0][7:0]  mem;
        logic [4:0]                 wptr;
        logic [4:0]                 pc;
        logic [4:0]                 label;
        logic [5:0]                 waitCnt;
        logic [7:0]                 x;
        logic [7:0]                 y;
        logic [7:0]                 z;
        logic [7:0]                 t;
        logic                       pause;
        logic [4:0]                 tickCnt;
        logic [7:0]                 sfrRdata;
        logic [7:0]                 rfRdata;
        logic [7:0]                 strobeCode;
        logic                       strobeValid;
        logic                       irqStop;
        logic                       irqWait;
        logic                       irqInt;
    } seq_regs_type;
endpackage
`default_nettype wire

// *** radio_strobe_sequencer.sv ***
// Command strobe and channel-access sequencer between CPU and radio.
// Assumes CPU bus, MAC timer events and radio flags all run on mclk.
`timescale 1ns/100ps
`default_nettype none
module radio_strobe_sequencer
    import radio_strobe_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // CPU special-function and radio-register access
    input  wire sfr_req_type sfrReq,
    output logic [7:0]       sfrRdata,
    input  wire rf_req_type  rfReq,
    output logic [7:0]       rfRdata,
    // MAC timer events and radio condition flags
    input  wire logic        macOverflow,
    input  wire logic        macCompareHit,
    input  wire logic [7:0]  radioFlags,
    // Strobes to the radio
    output logic             strobeValid,
    output logic [7:0]       strobeCode,
    // Interrupt requests, one-cycle pulses
    output logic             irqStop,
    output logic             irqWait,
    output logic             irqInt
);
    // ********************************
    // Decoding helpers
    // ********************************
    function automatic logic isImmediate(input logic [7:0] op);
        return op[7:5] == OP_IMM_TOP;
    endfunction

    function automatic logic condMet(input logic [7:0] op, input logic [7:0] flags);
        return flags[op[2:0]] ^ op[3];
    endfunction

    function automatic logic isUndefined(input logic [7:0] op);
        return (op[7:4] == 4'hb) && (op[3] == 1'b0 || op == 8'hbc || op[3:1] == 3'b111);
    endfunction

    function automatic seq_regs_type haltSeq(input seq_regs_type s, input logic clearProg);
        seq_regs_type r;
        r         = s;
        r.st      = ST_IDLE;
        r.pc      = '0;
        r.irqStop = 1'b1;
        if (clearProg)
        begin
            r.wptr = '0;
            r.mem  = {MEM_DEPTH{OP_NOP}};
        end
        return r;
    endfunction

    // ********************************
    // State and decoded strobes
    // ********************************
    seq_regs_type stateReg;
    seq_regs_type stateNext;
    logic         portWrite;
    logic         portRead;
    logic         immWrite;
    logic         tick;
    logic         running;
    logic [7:0]   curOp;
    logic [7:0]   execOp;

    // Access to the instruction port
    assign portWrite = sfrReq.write && (sfrReq.addr == PORT_ADDR);
    assign portRead  = sfrReq.read && (sfrReq.addr == PORT_ADDR);
    assign immWrite  = portWrite && isImmediate(sfrReq.wdata);
    assign tick      = stateReg.tickCnt == TICK_LAST;
    assign running   = stateReg.st != ST_IDLE;
    assign curOp     = stateReg.mem[stateReg.pc];
    // A waiting program sits one entry past the instruction that waits
    assign execOp    = (stateReg.st inside {ST_WAIT_OVF, ST_WAIT_EVT, ST_WAIT_X})
                       ? stateReg.mem[5'(stateReg.pc - 5'd1)] : curOp;

    // ********************************
    // Next-state logic
    // ********************************
    always_comb
    begin
        stateNext             = stateReg;
        stateNext.strobeValid = 1'b0;
        stateNext.irqStop     = 1'b0;
        stateNext.irqWait     = 1'b0;
        stateNext.irqInt      = 1'b0;
        stateNext.tickCnt     = tick ? '0 : 5'(stateReg.tickCnt + 5'd1);

        // Port read shows current opcode, no-op when idle or immediate
        if (portRead)
            stateNext.sfrRdata = (running && !immWrite) ? execOp : PORT_RESET;
        else if (sfrReq.read)
            stateNext.sfrRdata = 8'h00;

        // Radio register reads
        if (rfReq.read)
        begin
            unique case (rfReq.addr)
                RF_X_ADDR:    stateNext.rfRdata = stateReg.x;
                RF_Y_ADDR:    stateNext.rfRdata = stateReg.y;
                RF_Z_ADDR:    stateNext.rfRdata = stateReg.z;
                RF_T_ADDR:    stateNext.rfRdata = stateReg.t;
                RF_CTRL_ADDR: stateNext.rfRdata = 8'({running, 6'h00, stateReg.pause});
                default:      stateNext.rfRdata = 8'h00;
            endcase
        end

        // Countdown paced by timer overflows, halts at zero
        if (running && macOverflow && stateReg.t != T_HOLD_VALUE && stateReg.t != 8'h00)
        begin
            stateNext.t = 8'(stateReg.t - 8'd1);
            if (stateReg.t == 8'h01)
                stateNext = haltSeq(stateNext, 1'b0);
        end

        // Waiting states; a countdown halt in this cycle ends the wait too
        unique case (stateNext.st)
            ST_WAIT_OVF:
                if (macOverflow)
                begin
                    stateNext.waitCnt = 6'(stateReg.waitCnt - 6'd1);
                    if (stateReg.waitCnt == 6'd1)
                    begin
                        stateNext.st      = ST_RUN;
                        stateNext.irqWait = 1'b1;
                    end
                end
            ST_WAIT_X:
                if (macOverflow)
                begin
                    stateNext.x = 8'(stateReg.x - 8'd1);
                    if (stateReg.x == 8'd1)
                    begin
                        stateNext.st      = ST_RUN;
                        stateNext.irqWait = 1'b1;
                    end
                end
            ST_WAIT_EVT:
                if (macCompareHit)
                    stateNext.st = ST_RUN;
            default:
                ;
        endcase

        // A wait on the last entry ends the program when it completes
        if (stateReg.st != ST_RUN && stateNext.st == ST_RUN && stateReg.pc > MEM_LAST)
            stateNext = haltSeq(stateNext, 1'b0);

        // Program step; an immediate write delays it to the next tick
        if (stateReg.st == ST_RUN && stateNext.st == ST_RUN && tick && !immWrite && !stateReg.pause)
        begin
            stateNext.pc = 5'(stateReg.pc + 5'd1);
            if (stateReg.t == 8'h00)
                stateNext = haltSeq(stateNext, 1'b0);
            else if (curOp[7] == 1'b0)
            begin
                // Skip over S further entries when the condition holds
                if (condMet(curOp, radioFlags))
                    stateNext.pc = 5'(stateReg.pc + {2'b00, curOp[6:4]} + 5'd1);
            end
            else if (curOp[7:5] == OP_WAIT_TOP)
            begin
                stateNext.st      = ST_WAIT_OVF;
                stateNext.waitCnt = (curOp[4:0] == 5'd0) ? WAIT_ZERO_COUNT : {1'b0, curOp[4:0]};
            end
            else if (curOp[7:4] == OP_RPT_TOP)
            begin
                if (condMet(curOp, radioFlags))
                    stateNext.pc = stateReg.label;
            end
            else if (curOp == OP_WEVENT)
                stateNext.st = ST_WAIT_EVT;
            else if (curOp == OP_WAITX)
            begin
                if (stateReg.x != 8'h00)
                    stateNext.st = ST_WAIT_X;
            end
            else if (curOp == OP_LABEL)
                stateNext.label = 5'(stateReg.pc + 5'd1);
            else if (curOp == OP_INT)
                stateNext.irqInt = 1'b1;
            else if (curOp == OP_INCY)
                stateNext.y = 8'(stateReg.y + 8'd1);
            else if (curOp == OP_SSTOP)
                stateNext = haltSeq(stateNext, 1'b1);
            else if (curOp[7:5] == OP_STROBE_TOP)
            begin
                stateNext.strobeValid = 1'b1;
                stateNext.strobeCode  = curOp;
            end
            // Undefined opcodes only advance; unlike the no-op strobe, they issue no strobe

            // Running past the last entry stops the program
            if (stateNext.st == ST_RUN && stateReg.pc == MEM_LAST && stateNext.pc != stateReg.label)
                stateNext = haltSeq(stateNext, 1'b0);
            else if (stateNext.st == ST_RUN && stateNext.pc > MEM_LAST)
                stateNext = haltSeq(stateNext, 1'b0);
        end

        // Port writes: immediate commands or stored program bytes
        if (immWrite)
        begin
            if (sfrReq.wdata == OP_IMM_START)
            begin
                stateNext.st = ST_RUN;
                stateNext.pc = '0;
            end
            else if (sfrReq.wdata == OP_IMM_STOP)
                stateNext = haltSeq(stateNext, 1'b1);
            else
            begin
                stateNext.strobeValid = 1'b1;
                stateNext.strobeCode  = {OP_STROBE_TOP, sfrReq.wdata[4:0]};
            end
        end
        else if (portWrite && !running)
        begin
            stateNext.mem[stateReg.wptr] = sfrReq.wdata;
            if (stateReg.wptr != MEM_LAST)
                stateNext.wptr = 5'(stateReg.wptr + 5'd1);
        end

        // Radio register writes override hardware updates
        if (rfReq.write)
        begin
            unique case (rfReq.addr)
                RF_X_ADDR:    stateNext.x = rfReq.wdata;
                RF_Y_ADDR:    stateNext.y = rfReq.wdata;
                RF_Z_ADDR:    stateNext.z = rfReq.wdata;
                RF_T_ADDR:    stateNext.t = rfReq.wdata;
                RF_CTRL_ADDR: stateNext.pause = rfReq.wdata[CTRL_PAUSE_BIT];
                default:      ;
            endcase
        end
    end

    // ********************************
    // State register
    // ********************************
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stateReg             <= '0;
            stateReg.st          <= ST_IDLE;
            stateReg.mem         <= {MEM_DEPTH{OP_NOP}};
            stateReg.t           <= T_HOLD_VALUE;
            stateReg.sfrRdata    <= PORT_RESET;
        end
        else
            stateReg <= stateNext;
    end

    // Outputs straight from the state register
    assign sfrRdata    = stateReg.sfrRdata;
    assign rfRdata     = stateReg.rfRdata;
    assign strobeValid = stateReg.strobeValid;
    assign strobeCode  = stateReg.strobeCode;
    assign irqStop     = stateReg.irqStop;
    assign irqWait     = stateReg.irqWait;
    assign irqInt      = stateReg.irqInt;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    logic plainStep;
    assign plainStep = running && stateReg.st == ST_RUN && tick && !immWrite && !stateReg.pause
                       && stateReg.t != 8'h00 && !macOverflow && !rfReq.write;

    a_port_store: assert property (portWrite && !immWrite && !running
        |=> stateReg.mem[$past(stateReg.wptr)] == $past(sfrReq.wdata))
        else $error("port write not stored in memory");
    a_wptr_limit: assert property (stateReg.wptr <= MEM_LAST)
        else $error("write pointer beyond last entry");
    a_wptr_step: assert property (portWrite && !immWrite && !running && stateReg.wptr < MEM_LAST
        |=> stateReg.wptr == $past(stateReg.wptr) + 5'd1)
        else $error("write pointer did not advance");
    a_start_only: assert property (!running && !(immWrite && sfrReq.wdata == OP_IMM_START)
        |=> !running)
        else $error("execution began without start command");
    a_start_runs: assert property (immWrite && sfrReq.wdata == OP_IMM_START
        |=> stateReg.st == ST_RUN && stateReg.pc == 5'd0)
        else $error("start command did not start program");
    a_imm_strobe: assert property (immWrite && sfrReq.wdata != OP_IMM_START && sfrReq.wdata != OP_IMM_STOP
        |=> strobeValid && strobeCode[4:0] == $past(sfrReq.wdata[4:0]))
        else $error("immediate strobe not forwarded");
    a_idle_read: assert property (portRead && !running |=> sfrRdata == PORT_RESET)
        else $error("idle port read not no-op");
    a_run_read: assert property (portRead && running && !immWrite |=> sfrRdata == $past(execOp))
        else $error("port read not current opcode");
    a_last_stop: assert property (plainStep && stateReg.pc == MEM_LAST && curOp == OP_NOP
        |=> !running ##0 irqStop)
        else $error("no stop after last entry");
    a_undef_nop: assert property (plainStep && isUndefined(curOp) && stateReg.pc < MEM_LAST
        |=> stateReg.pc == $past(stateReg.pc) + 5'd1 && !strobeValid)
        else $error("undefined opcode not treated as no-op");
    a_count_halt: assert property (running && macOverflow && stateReg.t == 8'h01 && !rfReq.write
        && !immWrite |=> irqStop ##1 !irqStop)
        else $error("countdown end did not halt");

    c_program_start: cover property (immWrite && sfrReq.wdata == OP_IMM_START ##1 running);
    c_stop_irq: cover property (running ##1 irqStop);
    c_int_irq: cover property (irqInt);
    c_wait_done: cover property (stateReg.st == ST_WAIT_OVF ##1 irqWait);
endmodule
`default_nettype wire

// *** mac_radio_model.sv ***
// Far-side model: MAC timer overflow source and radio condition flags.
// Assumes the sequencer's clock and its active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module mac_radio_model
    import radio_strobe_pkg::*;
#(
    parameter int PERIOD = 40
)
(
    // Clock, reset and control
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       enable,
    // Timer events and flags
    output logic            macOverflow,
    output logic            macCompareHit,
    output logic [7:0]      radioFlags
);
    // ****************************************
    // Timer overflow generator
    // ****************************************
    logic [7:0] divCnt;

    // One overflow pulse per period while enabled
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divCnt      <= 8'h00;
            macOverflow <= 1'b0;
        end
        else
        begin
            macOverflow <= enable && (divCnt == 8'(PERIOD - 1));
            divCnt      <= (!enable || divCnt == 8'(PERIOD - 1)) ? 8'h00 : divCnt + 8'h01;
        end
    end

    // Compare never reached, flags static
    assign macCompareHit = 1'b0;
    assign radioFlags    = 8'h5a;
endmodule
`default_nettype wire

// *** radio_strobe_sequencer_tb.sv ***
// Self-checking bench for the radio strobe sequencer.
// Assumes the far-side model and drives the CPU side at falling edges.
`timescale 1ns/100ps
`default_nettype none
module radio_strobe_sequencer_tb
    import radio_strobe_pkg::*;
;
    // ****************************************
    // Signals, instances and monitors
    // ****************************************
    logic        mclk;
    logic        rst_b;
    logic        ovfEnable;
    sfr_req_type sfrReq;
    rf_req_type  rfReq;
    logic [7:0]  sfrRdata;
    logic [7:0]  rfRdata;
    logic [7:0]  strobeCode;
    logic [7:0]  radioFlags;
    logic [7:0]  lastStb;
    logic [7:0]  lastData;
    logic        strobeValid;
    logic        irqStop;
    logic        irqWait;
    logic        irqInt;
    logic        macOverflow;
    logic        macCompareHit;
    int          nMismatch;
    int          comparisons;
    int          nStop;
    int          nWait;
    int          nInt;
    int          nBad;
    int          k;

    radio_strobe_sequencer dut_u (.mclk(mclk), .rst_b(rst_b), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
        .rfReq(rfReq), .rfRdata(rfRdata), .macOverflow(macOverflow), .macCompareHit(macCompareHit),
        .radioFlags(radioFlags), .strobeValid(strobeValid), .strobeCode(strobeCode),
        .irqStop(irqStop), .irqWait(irqWait), .irqInt(irqInt));

    mac_radio_model #(.PERIOD(40)) model_u (.mclk(mclk), .rst_b(rst_b), .enable(ovfEnable),
        .macOverflow(macOverflow), .macCompareHit(macCompareHit), .radioFlags(radioFlags));

    // Clock source
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Pulse counters
    always @(posedge mclk)
    begin
        nStop += int'(irqStop);
        nWait += int'(irqWait);
        nInt  += int'(irqInt);
        nBad  += int'(strobeValid && strobeCode == 8'hc1);
    end

    // ****************************************
    // Access, compare and wait tasks
    // ****************************************
    task automatic report_and_stop();
        $display("Mismatches %0d, comparisons %0d", nMismatch, comparisons);
        if (nMismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_count(input int got, input int exp, input string what);
        comparisons++;
        if (got != exp)
        begin
            nMismatch++;
            $display("FAIL t=%0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    // Port access: request held one edge, answer taken one cycle later
    task automatic sfr_xfer(input logic [7:0] a, input logic wr, input logic [7:0] d);
        sfrReq = '{a, wr, !wr, d};
        @(posedge mclk);
        @(negedge mclk);
        lastStb  = strobeValid ? strobeCode : 8'h00;
        lastData = sfrRdata;
        sfrReq   = '{a, 1'b0, 1'b0, 8'h00};
        @(negedge mclk);
    endtask

    task automatic rf_xfer(input logic [2:0] a, input logic wr, input logic [7:0] d);
        rfReq = '{a, wr, !wr, d};
        @(posedge mclk);
        @(negedge mclk);
        lastData = rfRdata;
        rfReq    = '{a, 1'b0, 1'b0, 8'h00};
        @(negedge mclk);
    endtask

    function automatic int pick(input int sel);
        return (sel == 0) ? nStop : (sel == 1) ? nWait : nInt;
    endfunction

    // Bounded wait for a pulse counter to reach a target
    task automatic wait_irq(input int sel, input int target, input int bound);
        for (int i = 0; i < bound && pick(sel) < target; i++)
            @(negedge mclk);
        if (pick(sel) < target)
        begin
            nMismatch++;
            $display("FAIL t=%0t no interrupt pulse %0d", $time, sel);
            report_and_stop();
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        sfrReq      = '0;
        rfReq       = '0;
        ovfEnable   = 1'b1;
        rst_b       = 1'b0;
        nMismatch   = 0;
        comparisons = 0;
        nStop       = 0;
        nWait       = 0;
        nInt        = 0;
        nBad        = 0;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        // Reset values and unmapped address
        sfr_xfer(PORT_ADDR, 1'b0, 8'h00);
        cmp8(lastData, PORT_RESET, "port reset");
        sfr_xfer(8'he2, 1'b0, 8'h00);
        cmp8(lastData, 8'h00, "unmapped port");
        rf_xfer(RF_T_ADDR, 1'b0, 8'h00);
        cmp8(lastData, T_HOLD_VALUE, "countdown reset");
        // Every forwarded immediate strobe
        for (k = 0; k < 30; k++)
        begin
            sfr_xfer(PORT_ADDR, 1'b1, 8'he0 + 8'(k));
            cmp8(lastStb, 8'hc0 + 8'(k), "immediate strobe");
        end
        // Load wait and interrupt, not yet running
        sfr_xfer(PORT_ADDR, 1'b1, 8'h82);
        sfr_xfer(PORT_ADDR, 1'b1, OP_INT);
        sfr_xfer(PORT_ADDR, 1'b0, 8'h00);
        cmp8(lastData, PORT_RESET, "port after load");
        rf_xfer(RF_CTRL_ADDR, 1'b0, 8'h00);
        cmp8(lastData & 8'h80, 8'h00, "idle before start");
        // Start, observe wait, interrupt and end of memory
        sfr_xfer(PORT_ADDR, 1'b1, OP_IMM_START);
        rf_xfer(RF_CTRL_ADDR, 1'b0, 8'h00);
        cmp8(lastData & 8'h80, 8'h80, "running after start");
        repeat (30) @(negedge mclk);
        sfr_xfer(PORT_ADDR, 1'b0, 8'h00);
        cmp8(lastData, 8'h82, "current opcode");
        wait_irq(1, 1, 200);
        wait_irq(2, 1, 60);
        wait_irq(0, 1, 700);
        // Program kept after end, immediate stop clears it
        sfr_xfer(PORT_ADDR, 1'b1, OP_IMM_START);
        wait_irq(2, 2, 300);
        sfr_xfer(PORT_ADDR, 1'b1, OP_IMM_STOP);
        cmp_count(nStop, 2, "immediate stop");
        sfr_xfer(PORT_ADDR, 1'b1, OP_IMM_START);
        wait_irq(0, 3, 700);
        cmp_count(nInt, 2, "memory cleared");
        cmp_count(nWait, 2, "memory cleared waits");
        // Undefined opcode first, pointer saturates on last entry
        nBad = 0;
        sfr_xfer(PORT_ADDR, 1'b1, 8'hbc);
        for (k = 0; k < 22; k++)
            sfr_xfer(PORT_ADDR, 1'b1, OP_NOP);
        sfr_xfer(PORT_ADDR, 1'b1, 8'hc1);
        sfr_xfer(PORT_ADDR, 1'b1, OP_INT);
        sfr_xfer(PORT_ADDR, 1'b1, OP_IMM_START);
        wait_irq(0, 4, 700);
        cmp_count(nInt, 3, "last entry overwritten");
        cmp_count(nBad, 0, "overwritten strobe");
        // Countdown halts before the interrupt entry
        rf_xfer(RF_T_ADDR, 1'b1, 8'h02);
        sfr_xfer(PORT_ADDR, 1'b1, OP_IMM_START);
        wait_irq(0, 5, 200);
        cmp_count(nInt, 3, "countdown halt");
        report_and_stop();
    end
endmodule
`default_nettype wire
